//--- core/mac_config_vector_decode.sv
`timescale 1ns/1ps
module mac_config_vector_decode
  import cfg_vec_pkg::*;
#(
  parameter bit HALF_DUPLEX_CAPABLE = 1'b1
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Settings buses from user logic.
  input wire logic [TX_VEC_W-1:0] tx_settings,
  input wire logic [RX_VEC_W-1:0] rx_settings,
  // Frame activity from the frame engines.
  input wire logic tx_frame_active,
  input wire logic rx_frame_active,
  // Pause trigger from user logic.
  input wire logic pause_trigger,
  // Decoded controls to the frame engines.
  output tx_ctrl_t tx_ctrl,
  output rx_ctrl_t rx_ctrl,
  output logic tx_reset,
  output logic rx_reset,
  output logic pause_send
);


  // The settings buses are asynchronous user inputs, so each passes two
  // flops first. A multi-bit bus may be caught mid-change for one cycle;
  // the frame-boundary latch below accepts that since buses are static.

  // Synchroniser stages.
  logic [TX_VEC_W-1:0] tx_sync1_ff;
  logic [TX_VEC_W-1:0] tx_sync2_ff;
  logic [RX_VEC_W-1:0] rx_sync1_ff;
  logic [RX_VEC_W-1:0] rx_sync2_ff;
  logic pause_sync1_ff;
  logic pause_sync2_ff;
  logic [TX_VEC_W-1:0] nxt_tx_sync1;
  logic [TX_VEC_W-1:0] nxt_tx_sync2;
  logic [RX_VEC_W-1:0] nxt_rx_sync1;
  logic [RX_VEC_W-1:0] nxt_rx_sync2;
  logic nxt_pause_sync1;
  logic nxt_pause_sync2;

  // Transmit side state.
  tx_ctrl_t tx_ctrl_ff;
  tx_ctrl_t nxt_tx_ctrl;
  logic tx_reset_ff;
  logic nxt_tx_reset;
  logic tx_act_prev_ff;
  logic nxt_tx_act_prev;

  // Receive side state.
  rx_ctrl_t rx_ctrl_ff;
  rx_ctrl_t nxt_rx_ctrl;
  logic rx_reset_ff;
  logic nxt_rx_reset;
  logic rx_act_prev_ff;
  logic nxt_rx_act_prev;

  // Pause request state.
  logic pause_prev_ff;
  logic nxt_pause_prev;
  logic pause_send_ff;
  logic nxt_pause_send;

  // True only when no frame is in flight now or was one cycle ago.
  function automatic logic between_frames(
    input logic active,
    input logic active_prev
  );
    logic idle;
    idle = !active && !active_prev;
    return idle;
  endfunction

  function automatic logic [15:0] size_limit(
    input logic jumbo,
    input logic max_en,
    input logic vlan,
    input logic [15:0] prog_len
  );
    logic [15:0] lim;
    lim = vlan ? VLAN_MAX_LEN : LEGAL_MAX_LEN;
    if (jumbo)
    begin
      lim = JUMBO_MAX_LEN;
    end
    else if (max_en)
    begin
      // Frames must be shorter than the programmed length.
      lim = prog_len - 16'h0001;
    end
    return lim;
  endfunction

  // Full transmit decode of one settled bus value.
  function automatic tx_ctrl_t decode_tx(
    input logic [TX_VEC_W-1:0] vec
  );
    tx_ctrl_t ctl;
    ctl = TX_CTRL_RST;
    // A MAC built without half duplex never leaves full duplex.
    ctl.half_duplex = HALF_DUPLEX_CAPABLE &&
      vec[TX_HALF_BIT];
    // The gap input only matters in full duplex.
    ctl.ifg_from_input = vec[TX_IFG_BIT] &&
      !ctl.half_duplex;
    ctl.pause_enable = vec[TX_FC_BIT];
    ctl.user_fcs = vec[TX_FCS_BIT];
    ctl.auto_pad_fcs = !vec[TX_FCS_BIT];
    ctl.enable = vec[TX_EN_BIT];
    ctl.max_len = size_limit(vec[TX_JUMBO_BIT],
      vec[TX_MAXEN_BIT],
      vec[TX_VLAN_BIT],
      vec[TX_MAXLEN_HI:TX_MAXLEN_LO]);
    // Bit 0 of the field stays the individual/group bit.
    ctl.station_addr = vec[TX_ADDR_HI:TX_ADDR_LO];
    return ctl;
  endfunction

  // Full receive decode of one settled bus value.
  function automatic rx_ctrl_t decode_rx(
    input logic [RX_VEC_W-1:0] vec
  );
    rx_ctrl_t ctl;
    ctl = RX_CTRL_RST;
    ctl.half_duplex = HALF_DUPLEX_CAPABLE &&
      vec[RX_HALF_BIT];
    ctl.pause_enable = vec[RX_FC_BIT];
    ctl.pass_fcs = vec[RX_FCS_BIT];
    ctl.enable = vec[RX_EN_BIT];
    ctl.max_len = size_limit(vec[RX_JUMBO_BIT],
      vec[RX_MAXEN_BIT],
      vec[RX_VLAN_BIT],
      vec[RX_MAXLEN_HI:RX_MAXLEN_LO]);
    ctl.station_addr = vec[RX_ADDR_HI:RX_ADDR_LO];
    return ctl;
  endfunction

  // Synchroniser group.
  always_comb
  begin
    nxt_tx_sync1 = tx_settings;
    nxt_tx_sync2 = tx_sync1_ff;
    nxt_rx_sync1 = rx_settings;
    nxt_rx_sync2 = rx_sync1_ff;
    nxt_pause_sync1 = pause_trigger;
    nxt_pause_sync2 = pause_sync1_ff;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_sync1_ff <= '0;
      tx_sync2_ff <= '0;
      rx_sync1_ff <= '0;
      rx_sync2_ff <= '0;
      pause_sync1_ff <= 1'b0;
      pause_sync2_ff <= 1'b0;
    end
    else
    begin
      tx_sync1_ff <= nxt_tx_sync1;
      tx_sync2_ff <= nxt_tx_sync2;
      rx_sync1_ff <= nxt_rx_sync1;
      rx_sync2_ff <= nxt_rx_sync2;
      pause_sync1_ff <= nxt_pause_sync1;
      pause_sync2_ff <= nxt_pause_sync2;
    end
  end

  // Transmit group.
  always_comb
  begin
    nxt_tx_ctrl = tx_ctrl_ff;
    nxt_tx_act_prev = tx_frame_active;
    // The reset bit bypasses the frame boundary and acts at once.
    nxt_tx_reset = tx_sync2_ff[TX_RST_BIT];
    if (tx_sync2_ff[TX_RST_BIT])
    begin
      nxt_tx_ctrl = TX_CTRL_RST;
    end
    else if (between_frames(tx_frame_active, tx_act_prev_ff))
    begin
      // Waiting one idle cycle after a frame keeps a late end safe.
      nxt_tx_ctrl = decode_tx(tx_sync2_ff);
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_ctrl_ff <= TX_CTRL_RST;
      tx_reset_ff <= 1'b1;
      tx_act_prev_ff <= 1'b0;
    end
    else
    begin
      tx_ctrl_ff <= nxt_tx_ctrl;
      tx_reset_ff <= nxt_tx_reset;
      tx_act_prev_ff <= nxt_tx_act_prev;
    end
  end

  // Receive group.
  always_comb
  begin
    nxt_rx_ctrl = rx_ctrl_ff;
    nxt_rx_act_prev = rx_frame_active;
    nxt_rx_reset = rx_sync2_ff[RX_RST_BIT];
    if (rx_sync2_ff[RX_RST_BIT])
    begin
      nxt_rx_ctrl = RX_CTRL_RST;
    end
    else if (between_frames(rx_frame_active, rx_act_prev_ff))
    begin
      nxt_rx_ctrl = decode_rx(rx_sync2_ff);
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_ctrl_ff <= RX_CTRL_RST;
      rx_reset_ff <= 1'b1;
      rx_act_prev_ff <= 1'b0;
    end
    else
    begin
      rx_ctrl_ff <= nxt_rx_ctrl;
      rx_reset_ff <= nxt_rx_reset;
      rx_act_prev_ff <= nxt_rx_act_prev;
    end
  end

  // Pause group.
  always_comb
  begin
    nxt_pause_prev = pause_sync2_ff;
    nxt_pause_send = 1'b0;
    // One pulse per rising trigger while pause and transmit are enabled and out of reset; a held trigger does not repeat.
    if (pause_sync2_ff && !pause_prev_ff)
    begin
      nxt_pause_send = tx_ctrl_ff.pause_enable &&
        tx_ctrl_ff.enable &&
        !tx_reset_ff;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pause_prev_ff <= 1'b0;
      pause_send_ff <= 1'b0;
    end
    else
    begin
      pause_prev_ff <= nxt_pause_prev;
      pause_send_ff <= nxt_pause_send;
    end
  end

  // Every output is a flop, so the frame engines see no decode glitches.

  assign tx_ctrl = tx_ctrl_ff;
  assign rx_ctrl = rx_ctrl_ff;
  assign tx_reset = tx_reset_ff;
  assign rx_reset = rx_reset_ff;
  assign pause_send = pause_send_ff;

endmodule

//--- core/cfg_vec_pkg.sv
package cfg_vec_pkg;

  // Transmit settings bus field positions.
  localparam int TX_VEC_W = 80;
  localparam int TX_ADDR_HI = 79;
  localparam int TX_ADDR_LO = 32;
  localparam int TX_MAXLEN_HI = 31;
  localparam int TX_MAXLEN_LO = 16;
  localparam int TX_MAXEN_BIT = 14;
  localparam int TX_IFG_BIT = 8;
  localparam int TX_HALF_BIT = 6;
  localparam int TX_FC_BIT = 5;
  localparam int TX_JUMBO_BIT = 4;
  localparam int TX_FCS_BIT = 3;
  localparam int TX_VLAN_BIT = 2;
  localparam int TX_EN_BIT = 1;
  localparam int TX_RST_BIT = 0;

  // Receive settings bus field positions.
  localparam int RX_VEC_W = 80;
  localparam int RX_ADDR_HI = 79;
  localparam int RX_ADDR_LO = 32;
  localparam int RX_MAXLEN_HI = 31;
  localparam int RX_MAXLEN_LO = 16;
  localparam int RX_MAXEN_BIT = 14;
  localparam int RX_HALF_BIT = 6;
  localparam int RX_FC_BIT = 5;
  localparam int RX_JUMBO_BIT = 4;
  localparam int RX_FCS_BIT = 3;
  localparam int RX_VLAN_BIT = 2;
  localparam int RX_EN_BIT = 1;
  localparam int RX_RST_BIT = 0;

  // Frame length limits in bytes.
  localparam logic [15:0] LEGAL_MAX_LEN = 16'h05ee;
  localparam logic [15:0] VLAN_MAX_LEN = 16'h05f2;
  localparam logic [15:0] JUMBO_MAX_LEN = 16'hffff;
  localparam logic [15:0] MIN_FRAME_LEN = 16'h0040;

  // Decoded transmitter controls.
  typedef struct packed {
    logic ifg_from_input;
    logic half_duplex;
    logic pause_enable;
    logic user_fcs;
    logic auto_pad_fcs;
    logic enable;
    logic [15:0] max_len;
    logic [47:0] station_addr;
  } tx_ctrl_t;

  // Decoded receiver controls.
  typedef struct packed {
    logic half_duplex;
    logic pause_enable;
    logic pass_fcs;
    logic enable;
    logic [15:0] max_len;
    logic [47:0] station_addr;
  } rx_ctrl_t;

  localparam tx_ctrl_t TX_CTRL_RST = '0;
  localparam rx_ctrl_t RX_CTRL_RST = '0;

endpackage

//--- tb/cfg_vec_props_properties.sv
`timescale 1ns/1ps
module cfg_vec_props
  import cfg_vec_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Inputs of the decoder.
  input wire logic [TX_VEC_W-1:0] tx_settings,
  input wire logic [RX_VEC_W-1:0] rx_settings,
  input wire logic tx_frame_active,
  input wire logic rx_frame_active,
  input wire logic pause_trigger,
  // Outputs of the decoder.
  input wire tx_ctrl_t tx_ctrl,
  input wire rx_ctrl_t rx_ctrl,
  input wire logic tx_reset,
  input wire logic rx_reset,
  input wire logic pause_send
);
  // Counts edges since reset so that the sync pipeline has filled.
  logic [2:0] up_ff;
  logic [2:0] nxt_up;
  always_comb nxt_up = (up_ff == 3'h7) ? up_ff : up_ff + 3'h1;
  always_ff @(posedge clk or negedge resetn)
    if (!resetn) up_ff <= 3'h0;
    else up_ff <= nxt_up;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence tx_idle;
    !tx_frame_active [*4] ##0 (up_ff == 3'h7) && !tx_reset;
  endsequence
  sequence rx_idle;
    !rx_frame_active [*4] ##0 (up_ff == 3'h7) && !rx_reset;
  endsequence
  AST_TX_RST: assert property (up_ff == 3'h7 |-> tx_reset ==
    $past(tx_settings[TX_RST_BIT], 3)) else $error("tx reset lag");
  AST_RX_RST: assert property (up_ff == 3'h7 |-> rx_reset ==
    $past(rx_settings[RX_RST_BIT], 3)) else $error("rx reset lag");
  AST_TX_ZERO: assert property (tx_reset |-> tx_ctrl == TX_CTRL_RST)
    else $error("tx ctrl not cleared");
  AST_TX_EN: assert property (tx_idle |-> tx_ctrl.enable ==
    $past(tx_settings[TX_EN_BIT], 3)) else $error("tx enable");
  AST_TX_HALF: assert property (tx_idle |-> tx_ctrl.half_duplex ==
    $past(tx_settings[TX_HALF_BIT], 3)) else $error("tx duplex");
  AST_TX_IFG: assert property (tx_idle |-> tx_ctrl.ifg_from_input ==
    ($past(tx_settings[TX_IFG_BIT], 3) && !tx_ctrl.half_duplex))
    else $error("tx gap select");
  AST_RX_ADDR: assert property (rx_idle |-> rx_ctrl.station_addr ==
    $past(rx_settings[RX_ADDR_HI:RX_ADDR_LO], 3)) else $error("rx addr");
  AST_TX_HOLD: assert property ($past(tx_frame_active) && !tx_reset &&
    !$past(tx_reset) |-> $stable(tx_ctrl)) else $error("tx ctrl moved");
  AST_RX_HOLD: assert property ($past(rx_frame_active) && !rx_reset &&
    !$past(rx_reset) |-> $stable(rx_ctrl)) else $error("rx ctrl moved");
  AST_PAUSE: assert property ($rose(pause_trigger) ##2
    (tx_ctrl.pause_enable && tx_ctrl.enable && !tx_reset) |-> ##1 pause_send)
    else $error("pause missing");
  AST_PAUSE_GATE: assert property (pause_send |->
    ($past(tx_ctrl.pause_enable) && $past(tx_ctrl.enable) &&
    !$past(tx_reset)) ##1 !pause_send) else $error("pause bad");
endmodule
bind mac_config_vector_decode cfg_vec_props u_props (.*);

//--- tb/user_cfg_model.sv
`timescale 1ns/1ps
module user_cfg_model
  import cfg_vec_pkg::*;
(
  // Requests from the bench.
  input wire logic [TX_VEC_W-1:0] tx_req,
  input wire logic [RX_VEC_W-1:0] rx_req,
  input wire logic pause_req,
  // Settings buses to the decoder.
  output logic [TX_VEC_W-1:0] tx_settings,
  output logic [RX_VEC_W-1:0] rx_settings,
  output logic pause_trigger
);
  // Short limits are lifted, since ordinary frames would be refused.
  logic [15:0] len;
  assign len = rx_req[31:16] < LEGAL_MAX_LEN ? LEGAL_MAX_LEN :
    rx_req[31:16];
  // Transmit bus passes as asked; with bit 3 set the user owns FCS.
  assign rx_settings = {rx_req[79:32], len, rx_req[15:0]};
  assign tx_settings = tx_req;
  assign pause_trigger = pause_req;
endmodule

//--- tb/test_mac_config_vector_decode.sv
`timescale 1ns/1ps
module test_mac_config_vector_decode;
  import cfg_vec_pkg::*;
  logic clk = 0;
  logic resetn = 0;
  logic [79:0] tx_req = '0;
  logic [79:0] rx_req = '0;
  logic pause_req = 0;
  logic tx_act = 0;
  logic rx_act = 0;
  logic [79:0] txs;
  logic [79:0] rxs;
  logic pt;
  tx_ctrl_t tx_ctrl;
  rx_ctrl_t rx_ctrl;
  logic tx_reset;
  logic rx_reset;
  logic pause_send;
  int errors = 0;
  int checks_done = 0;
  int n;
  always #12.5 clk = ~clk;
  user_cfg_model model (.tx_req(tx_req), .rx_req(rx_req),
    .pause_req(pause_req), .tx_settings(txs), .rx_settings(rxs),
    .pause_trigger(pt));
  mac_config_vector_decode dut (.clk(clk), .resetn(resetn),
    .tx_settings(txs), .rx_settings(rxs), .tx_frame_active(tx_act),
    .rx_frame_active(rx_act), .pause_trigger(pt), .tx_ctrl(tx_ctrl),
    .rx_ctrl(rx_ctrl), .tx_reset(tx_reset), .rx_reset(rx_reset),
    .pause_send(pause_send));
  function logic [15:0] lim(logic [79:0] v);
    lim = v[4] ? 16'hffff : v[14] ? v[31:16] - 16'h0001 :
      v[2] ? 16'h05f2 : 16'h05ee;
  endfunction
  function tx_ctrl_t etx(logic [79:0] v);
    etx = v[0] ? '0 : {v[8] & ~v[6], v[6], v[5], v[3], ~v[3], v[1],
      lim(v), v[79:32]};
  endfunction
  function rx_ctrl_t erx(logic [79:0] v);
    erx = v[0] ? '0 : {v[6], v[5], v[3], v[1], lim(v), v[79:32]};
  endfunction
  function logic [79:0] rv;
    rv = 80'({$urandom, $urandom, $urandom});
    rv[0] = ($urandom % 4 == 0);
  endfunction
  task check(logic [79:0] seen, logic [79:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task final_report;
    if (errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task apply(logic [79:0] t, logic [79:0] r);
    @(posedge clk);
    tx_req <= t;
    rx_req <= r;
    repeat (8) @(negedge clk);
  endtask
  task cmp_all;
    check(80'(tx_ctrl), 80'(etx(txs)));
    check(80'(rx_ctrl), 80'(erx(rxs)));
    check(80'({tx_reset, rx_reset}), 80'({txs[0], rxs[0]}));
  endtask
  initial
  begin
    #100000;
    errors++;
    final_report;
  end
  initial
  begin
    n = $urandom(12);
    repeat (16) @(posedge clk);
    resetn <= 1;
    apply(80'h0a0b0c0d0e01_05ee_4002, 80'h0a0b0c0d0e01_05ee_4002);
    cmp_all;
    repeat (40)
    begin
      apply(rv(), rv());
      cmp_all;
    end
    // A frame in flight keeps the old controls until it ends.
    apply(80'h2, 80'h2);
    @(posedge clk);
    tx_act <= 1;
    rx_act <= 1;
    tx_req <= 80'h0;
    rx_req <= 80'h0;
    repeat (8) @(negedge clk);
    check(80'({tx_ctrl.enable, rx_ctrl.enable}), 80'h3);
    @(posedge clk);
    tx_act <= 0;
    rx_act <= 0;
    repeat (8) @(negedge clk);
    cmp_all;
    for (int fc = 0; fc < 2; fc++)
    begin
      apply({74'h0, fc[0], 5'h02}, 80'h2);
      @(posedge clk);
      pause_req <= 1;
      @(posedge clk);
      pause_req <= 0;
      n = 0;
      repeat (8)
      begin
        @(negedge clk);
        if (pause_send === 1'b1) n++;
      end
      check(80'(n), 80'(fc));
    end
    final_report;
  end
endmodule
